// ### lvds_ctrl_pkg.sv
// Register map, field layout and reset values of the LVDS control bank
package lvds_ctrl_pkg;
  localparam logic [7:0] ADDR_POWER_DOWN = 8'h76;
  localparam logic [7:0] ADDR_PLL_LOOP = 8'h78;
  localparam logic [7:0] ADDR_SLIP_LIMIT = 8'h7F;
  localparam logic [7:0] ADDR_PULLDOWN = 8'h74;
  localparam logic [7:0] RST_POWER_DOWN = 8'hAD;
  localparam logic [7:0] RST_PLL_LOOP = 8'h38;
  localparam logic [7:0] RST_SLIP_LIMIT = 8'h10;
  localparam logic [7:0] RST_PULLDOWN = 8'hC0;
  localparam int PD_OUT_POWER_BIT = 0;
  localparam int PD_PLL_RESET_BIT = 2;
  localparam int PD_PLL_POWER_BIT = 3;
  localparam int PD_LF_RES_LSB = 4;
  localparam int PD_FIFO_RESET_BIT = 7;
  localparam int LC_PHASE_DET_LSB = 0;
  localparam int LC_LF_CAP_LSB = 5;
  localparam int LC_SPER_BIT = 7;
  localparam int PULLDOWN_BIT = 7;
  localparam logic [7:0] PD_WRITE_MASK = 8'hFF;
endpackage

// ### lvds_out_drive.sv
`timescale 1ns/1ps
// Output pad state for the LVDS data and clock lanes
module lvds_out_drive (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic power_n,
  input wire logic pulldown_en,
  output logic drive_en,
  output logic pulldown_on,
  output logic tristate_on
);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      drive_en <= 1'b0;
      pulldown_on <= 1'b0;
      tristate_on <= 1'b1;
    end else begin
      drive_en <= power_n;
      pulldown_on <= !power_n && pulldown_en;
      tristate_on <= !power_n && !pulldown_en;
    end
  end
endmodule // lvds_out_drive

// ### lvds_pll_power_ctrl_regs.sv
`timescale 1ns/1ps
// LVDS power-down, PLL loop and FIFO slip limit register bank

module lvds_pll_power_ctrl_regs
  import lvds_ctrl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  output logic output_path_power_n,
  output logic output_pulldown_en,
  output logic pll_reset_n,
  output logic pll_power_n,
  output logic [2:0] pll_loop_res_sel,
  output logic [1:0] pll_loop_cap_sel,
  output logic [4:0] phase_detector_ctrl,
  output logic static_phase_err_reduce_en,
  output logic fifo_reset_n,
  output logic [7:0] fifo_slip_limit,
  output logic lane_drive_en,
  output logic lane_pulldown_on,
  output logic lane_tristate_on
);
  // Storage slots of the bank; the address map lives in the package
  localparam int NUM_REGS = 4;
  localparam int REG_W = 8;
  localparam int SLOT_PULLDOWN = 0;
  localparam int SLOT_POWER_DOWN = 1;
  localparam int SLOT_PLL_LOOP = 2;
  localparam int SLOT_SLIP_LIMIT = 3;

  typedef logic [NUM_REGS-1:0] slot_sel_t;

  logic [REG_W-1:0] bank_reg [NUM_REGS];
  logic [REG_W-1:0] lvds_power_down_ctrl_reg;
  logic [REG_W-1:0] lvds_pll_loop_ctrl_reg;
  logic [REG_W-1:0] fifo_slip_limit_reg;
  logic [REG_W-1:0] pulldown_ctrl_reg;
  slot_sel_t wr_sel;
  slot_sel_t rd_sel;
  logic [REG_W-1:0] rdata_next;
  logic hit_next;

  // Every field slice and bit must sit inside one register byte
  if (PD_LF_RES_LSB + $bits(pll_loop_res_sel) > REG_W) begin : g_bad_res
    $error("Loop resistor field runs past its register");
  end
  if (LC_LF_CAP_LSB + $bits(pll_loop_cap_sel) > REG_W) begin : g_bad_cap
    $error("Loop capacitor field runs past its register");
  end
  if (LC_PHASE_DET_LSB + $bits(phase_detector_ctrl) > REG_W) begin : g_bad_pd
    $error("Phase detector field runs past its register");
  end
  if (PD_OUT_POWER_BIT >= REG_W) begin : g_bad_out
    $error("Output power bit lies outside its register");
  end
  if (PD_PLL_RESET_BIT >= REG_W) begin : g_bad_prst
    $error("PLL reset bit lies outside its register");
  end
  if (PD_PLL_POWER_BIT >= REG_W) begin : g_bad_ppwr
    $error("PLL power bit lies outside its register");
  end
  if (PD_FIFO_RESET_BIT >= REG_W) begin : g_bad_fifo
    $error("FIFO reset bit lies outside its register");
  end
  if (LC_SPER_BIT >= REG_W) begin : g_bad_sper
    $error("Phase error bit lies outside its register");
  end
  if (PULLDOWN_BIT >= REG_W) begin : g_bad_pull
    $error("Pull-down bit lies outside its register");
  end

  // One-hot slot for an address, shared by the write and read paths
  function automatic slot_sel_t decode_slot(logic [7:0] addr);
    slot_sel_t sel;
    sel = '0;
    unique case (addr)
      ADDR_PULLDOWN: sel[SLOT_PULLDOWN] = 1'b1;
      ADDR_POWER_DOWN: sel[SLOT_POWER_DOWN] = 1'b1;
      ADDR_PLL_LOOP: sel[SLOT_PLL_LOOP] = 1'b1;
      ADDR_SLIP_LIMIT: sel[SLOT_SLIP_LIMIT] = 1'b1;
      default: sel = '0;
    endcase
    return sel;
  endfunction

  // Value a slot takes while nrst is low
  function automatic logic [REG_W-1:0] slot_reset_value(int slot);
    logic [REG_W-1:0] value;
    value = '0;
    unique case (slot)
      SLOT_PULLDOWN: value = RST_PULLDOWN;
      SLOT_POWER_DOWN: value = RST_POWER_DOWN;
      SLOT_PLL_LOOP: value = RST_PLL_LOOP;
      SLOT_SLIP_LIMIT: value = RST_SLIP_LIMIT;
      default: value = '0;
    endcase
    return value;
  endfunction

  // Unmapped writes select no slot and are dropped silently
  assign wr_sel = reg_wr ? decode_slot(reg_addr) : '0;
  assign rd_sel = decode_slot(reg_addr);

  // One storage byte per slot, reset constant fixed per slot
  // Same logic for all four, so a new slot costs one entry in the decode table and one in the reset table
  for (genvar g = 0; g < NUM_REGS; g++) begin : g_slot
    localparam logic [REG_W-1:0] RESET_VALUE = slot_reset_value(g);
    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        bank_reg[g] <= RESET_VALUE;
      end else if (wr_sel[g]) begin
        bank_reg[g] <= reg_wdata;
      end
    end
  end

  // Named views of the slots; every bit, reserved ones too, is kept
  assign pulldown_ctrl_reg = bank_reg[SLOT_PULLDOWN];
  assign lvds_power_down_ctrl_reg = bank_reg[SLOT_POWER_DOWN];
  assign lvds_pll_loop_ctrl_reg = bank_reg[SLOT_PLL_LOOP];
  assign fifo_slip_limit_reg = bank_reg[SLOT_SLIP_LIMIT];

  // Read mux; a read in a write cycle returns the old byte
  always_comb begin
    rdata_next = '0;
    hit_next = |rd_sel;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (rd_sel[i]) begin
        rdata_next = bank_reg[i];
      end
    end
  end

  // Read data registered one cycle after the strobe; holds otherwise
  // Hit lets software tell an unmapped read from a zero byte
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
      reg_hit <= 1'b0;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
      reg_hit <= hit_next;
    end
  end

  // Output path controls, registered so the pads see no decode glitch
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      output_path_power_n <= RST_POWER_DOWN[PD_OUT_POWER_BIT];
      output_pulldown_en <= RST_PULLDOWN[PULLDOWN_BIT];
    end else begin
      output_path_power_n <=
        lvds_power_down_ctrl_reg[PD_OUT_POWER_BIT];
      output_pulldown_en <= pulldown_ctrl_reg[PULLDOWN_BIT];
    end
  end

  // PLL reset, power and loop settings
  // Phase error reduction is best left at its reset value
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pll_reset_n <= RST_POWER_DOWN[PD_PLL_RESET_BIT];
      pll_power_n <= RST_POWER_DOWN[PD_PLL_POWER_BIT];
      pll_loop_res_sel <= RST_POWER_DOWN[PD_LF_RES_LSB +: 3];
      pll_loop_cap_sel <= RST_PLL_LOOP[LC_LF_CAP_LSB +: 2];
      phase_detector_ctrl <= RST_PLL_LOOP[LC_PHASE_DET_LSB +: 5];
      static_phase_err_reduce_en <= RST_PLL_LOOP[LC_SPER_BIT];
    end else begin
      pll_reset_n <= lvds_power_down_ctrl_reg[PD_PLL_RESET_BIT];
      pll_power_n <= lvds_power_down_ctrl_reg[PD_PLL_POWER_BIT];
      pll_loop_res_sel <=
        lvds_power_down_ctrl_reg[PD_LF_RES_LSB +: 3];
      pll_loop_cap_sel <= lvds_pll_loop_ctrl_reg[LC_LF_CAP_LSB +: 2];
      phase_detector_ctrl <=
        lvds_pll_loop_ctrl_reg[LC_PHASE_DET_LSB +: 5];
      static_phase_err_reduce_en <=
        lvds_pll_loop_ctrl_reg[LC_SPER_BIT];
    end
  end

  // FIFO reset and slip limit
  // Limit is only held here; slip counting per frame lives elsewhere
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fifo_reset_n <= RST_POWER_DOWN[PD_FIFO_RESET_BIT];
      fifo_slip_limit <= RST_SLIP_LIMIT;
    end else begin
      fifo_reset_n <= lvds_power_down_ctrl_reg[PD_FIFO_RESET_BIT];
      fifo_slip_limit <= fifo_slip_limit_reg;
    end
  end

  // Pad state follows the register bits directly, one flop stage
  lvds_out_drive u_out_drive (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .power_n(lvds_power_down_ctrl_reg[PD_OUT_POWER_BIT]),
    .pulldown_en(pulldown_ctrl_reg[PULLDOWN_BIT]),
    .drive_en(lane_drive_en),
    .pulldown_on(lane_pulldown_on),
    .tristate_on(lane_tristate_on)
  );
endmodule // lvds_pll_power_ctrl_regs

// ### lvds_regs_checker.sv
// Assertions on the LVDS control register bank ports
`timescale 1ns/1ps
module lvds_regs_checker
  import lvds_ctrl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic output_pulldown_en,
  input wire logic [1:0] pll_loop_cap_sel,
  input wire logic lane_drive_en,
  input wire logic lane_pulldown_on,
  input wire logic lane_tristate_on,
  input wire logic output_path_power_n,
  input wire logic pll_reset_n,
  input wire logic pll_power_n,
  input wire logic [2:0] pll_loop_res_sel,
  input wire logic [4:0] phase_detector_ctrl,
  input wire logic static_phase_err_reduce_en,
  input wire logic fifo_reset_n,
  input wire logic [7:0] fifo_slip_limit
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  wire [7:0] wd = reg_wdata;
  wire w_pd = reg_wr && reg_addr == ADDR_POWER_DOWN;
  wire w_lc = reg_wr && reg_addr == ADDR_PLL_LOOP;
  wire w_lim = reg_wr && reg_addr == ADDR_SLIP_LIMIT;
  logic armed_reg;
  // Lane flops reset to a safe float, so skip the first edge after reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      armed_reg <= 1'b0;
    end else begin
      armed_reg <= 1'b1;
    end
  end
  // Two edges: register, then output copy
  property p_opw;
    w_pd |-> ##2 output_path_power_n == $past(wd[0], 2); endproperty
  a_opw: assert property (p_opw) else $error("out power");
  property p_rst; w_pd |-> ##2 pll_reset_n == $past(wd[2], 2); endproperty
  a_rst: assert property (p_rst) else $error("pll reset");
  property p_pwr; w_pd |-> ##2 pll_power_n == $past(wd[3], 2); endproperty
  a_pwr: assert property (p_pwr) else $error("pll power");
  property p_res;
    w_pd |-> ##2 pll_loop_res_sel == $past(wd[6:4], 2); endproperty
  a_res: assert property (p_res) else $error("loop res");
  property p_fifo; w_pd |-> ##2 fifo_reset_n == $past(wd[7], 2); endproperty
  a_fifo: assert property (p_fifo) else $error("fifo reset");
  property p_pd;
    w_lc |-> ##2 phase_detector_ctrl == $past(wd[4:0], 2); endproperty
  a_pd: assert property (p_pd) else $error("phase det");
  property p_sper;
    w_lc |-> ##2 static_phase_err_reduce_en == $past(wd[7], 2); endproperty
  a_sper: assert property (p_sper) else $error("phase err");
  property p_lim; w_lim |-> ##2 fifo_slip_limit == $past(wd, 2); endproperty
  a_lim: assert property (p_lim) else $error("slip limit");
  property p_cap;
    w_lc |-> ##2 pll_loop_cap_sel == $past(wd[6:5], 2); endproperty
  a_cap: assert property (p_cap) else $error("loop cap");
  property p_lane;
    armed_reg |-> lane_drive_en == output_path_power_n &&
      lane_pulldown_on == (!output_path_power_n && output_pulldown_en) &&
      lane_tristate_on == (!output_path_power_n && !output_pulldown_en);
  endproperty
  a_lane: assert property (p_lane) else $error("lane state");
  c_pull: cover property (lane_pulldown_on);
  c_off: cover property (w_pd && !wd[0]);
  c_loop: cover property (w_lc);
  c_lim: cover property (w_lim);
endmodule // lvds_regs_checker
bind lvds_pll_power_ctrl_regs lvds_regs_checker chk_u (.*);

// ### lvds_pll_power_ctrl_regs_tb_top.sv
// Random and corner tests of the LVDS control register bank
`timescale 1ns/1ps
module lvds_pll_power_ctrl_regs_tb_top;
  import lvds_ctrl_pkg::*;
  logic clk_sys = 0, nrst = 0, reg_wr = 0, reg_rd = 0, reg_hit;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, p, c, l, q;
  logic output_path_power_n, output_pulldown_en, pll_reset_n, pll_power_n;
  logic static_phase_err_reduce_en, fifo_reset_n, lane_drive_en;
  logic lane_pulldown_on, lane_tristate_on;
  logic [2:0] pll_loop_res_sel;
  logic [1:0] pll_loop_cap_sel;
  logic [4:0] phase_detector_ctrl;
  logic [7:0] fifo_slip_limit;
  int miscompares = 0, n_compared = 0;
  lvds_pll_power_ctrl_regs dut_u (.*);
  initial forever #5 clk_sys = ~clk_sys;
  task automatic chk(string nm, logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (miscompares == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Strobe held over exactly one rising edge
  task automatic bus(logic w, logic [7:0] a, v);
    @(negedge clk_sys);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, v};
    @(negedge clk_sys);
    {reg_wr, reg_rd} = 2'b00;
  endtask
  task automatic rd(logic [7:0] a, exp, logic hit);
    bus(1'b0, a, 8'h00);
    chk("rdata", reg_rdata, exp);
    chk("hit", {7'h00, reg_hit}, {7'h00, hit});
  endtask
  function automatic logic [7:0] lanes(logic pw, pd);
    return {4'h0, pw, !pw && pd, !pw && !pd, pd};
  endfunction
  // Write all four registers from p, c, l, q, read back, check fields
  task automatic write_and_check();
    logic [7:0] s;
    bus(1'b1, ADDR_POWER_DOWN, p);
    bus(1'b1, ADDR_PLL_LOOP, c);
    bus(1'b1, ADDR_SLIP_LIMIT, l);
    bus(1'b1, ADDR_PULLDOWN, q);
    bus(1'b1, 8'h77, ~p);
    rd(8'h77, 8'h00, 1'b0);
    rd(ADDR_POWER_DOWN, p, 1'b1);
    rd(ADDR_PLL_LOOP, c, 1'b1);
    rd(ADDR_SLIP_LIMIT, l, 1'b1);
    rd(ADDR_PULLDOWN, q, 1'b1);
    s = {fifo_reset_n, pll_loop_res_sel, pll_power_n, pll_reset_n, 1'b0,
      output_path_power_n};
    chk("power", s, {p[7:2], 1'b0, p[0]});
    s = {static_phase_err_reduce_en, pll_loop_cap_sel, phase_detector_ctrl};
    chk("loop", s, c);
    chk("limit", fifo_slip_limit, l);
    s = {4'h0, lane_drive_en, lane_pulldown_on, lane_tristate_on,
      output_pulldown_en};
    chk("lanes", s, lanes(p[0], q[7]));
  endtask
  initial begin
    void'($urandom(32'h55D8354B));
    repeat (2) @(negedge clk_sys);
    nrst = 1;
    rd(ADDR_POWER_DOWN, RST_POWER_DOWN, 1'b1);
    rd(ADDR_PLL_LOOP, RST_PLL_LOOP, 1'b1);
    rd(ADDR_SLIP_LIMIT, RST_SLIP_LIMIT, 1'b1);
    rd(ADDR_PULLDOWN, RST_PULLDOWN, 1'b1);
    // Panel values for the highest resolution as a fixed corner
    {p, c, l, q} = {8'hAF, 8'h80, 8'h10, 8'hF6};
    write_and_check();
    for (int i = 0; i < 32; i++) begin
      {p, c, l, q} = $urandom;
      {p[6:4], p[0], q[7]} = i[4:0];
      write_and_check();
    end
    end_of_test();
  end
  // About 700 cycles expected; allow three times that
  initial begin
    #20000;
    miscompares++;
    end_of_test();
  end
endmodule // lvds_pll_power_ctrl_regs_tb_top
